// ==== rtl/rxu_consts.svh ====
// constants of the receive burst interface: offsets, fields, counts
// assumes nothing; included by the package and by the design modules
`ifndef RXU_CONSTS_SVH
`define RXU_CONSTS_SVH

// ----------------------------------------------------------------
// data bus geometry
// ----------------------------------------------------------------
`define RXU_WORDS          8
`define RXU_WORD_BITS      64
`define RXU_WORD_BYTES     8
`define RXU_CHAN_BITS      8
`define RXU_CNT_FULL       4'h8
`define RXU_CNT_IDLE       4'h0
`define RXU_EOP_NONE       4'h0
`define RXU_NV_LOW_UNUSED  4'h0

// ----------------------------------------------------------------
// reset and bring-up
// ----------------------------------------------------------------
`define RXU_SEQ_CYCLES     8'h20
`define RXU_SEQ_ONE        8'h01

// ----------------------------------------------------------------
// register map, byte offsets and fields
// ----------------------------------------------------------------
`define RXU_ADR_CTRL       5'h00
`define RXU_ADR_STATUS     5'h04
`define RXU_ADR_BEATS      5'h08
`define RXU_ADR_PKTS       5'h0C
`define RXU_ADR_ERRS       5'h10
`define RXU_CTRL_EN        0
`define RXU_CTRL_CLR       1
`define RXU_ST_READY       0
`define RXU_ST_TXAL        1
`define RXU_ST_WORD        2
`define RXU_ST_FRAME       3
`define RXU_ST_RXAL        4
`define RXU_ST_FULL        5
`define RXU_ST_EMPTY       6
`define RXU_ST_BADCNT      8
`define RXU_CNT_ONE        32'h0000_0001

`endif

// ==== rtl/rxu_pkg.sv ====
// types shared by the receive burst interface modules
// assumes rxu_consts.svh is on the include path
`include "rxu_consts.svh"

package rxu_pkg;

	// ------------------------------------------------------------
	// beat arriving from the deframer, words packed from word 0 up
	// ------------------------------------------------------------
	typedef struct packed {
		logic                                   sop;
		logic                                   eob;
		logic                                   eop;
		logic [`RXU_CHAN_BITS-1:0]              chan;
		logic [3:0]                             count;
		logic [2:0]                             last_bytes;
		logic [`RXU_WORDS*`RXU_WORD_BITS-1:0]   data;
	} rxu_in_t;

	// ------------------------------------------------------------
	// beat as delivered to the application
	// ------------------------------------------------------------
	typedef struct packed {
		logic [1:0]                             sop;
		logic [1:0]                             sob;
		logic                                   eob;
		logic [`RXU_CHAN_BITS-1:0]              chan;
		logic [7:0]                             num_valid;
		logic [3:0]                             eopbits;
		logic [`RXU_WORDS*`RXU_WORD_BITS-1:0]   data;
	} rxu_beat_t;

	// bring-up states
	typedef enum logic [1:0] {
		ST_RESET = 2'b00,
		ST_SEQ   = 2'b01,
		ST_LINK  = 2'b10,
		ST_UP    = 2'b11
	} rxu_state_t;

endpackage

// ==== rtl/rxu_skid.sv ====
// two-entry buffer holding delivered beats
// assumes a synchronous active-high reset from the core's own sync
`timescale 1ns/1ps
`include "rxu_consts.svh"

module rxu_skid (
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	input  wire logic              in_valid_i,
	output logic                   in_ready_o,
	input  wire rxu_pkg::rxu_beat_t in_beat_i,
	output logic                   out_valid_o,
	input  wire logic              out_ready_i,
	output rxu_pkg::rxu_beat_t     out_beat_o,
	output logic                   full_o,
	output logic                   empty_o
);

	rxu_pkg::rxu_beat_t skid;
	logic               skid_v;
	logic               push;
	logic               pop;

	// ------------------------------------------------------------
	// handshakes
	// ------------------------------------------------------------
	// second entry free means a word can always be caught
	assign in_ready_o = ~skid_v;
	assign push       = in_valid_i & in_ready_o;
	assign pop        = out_valid_o & out_ready_i;
	assign full_o     = skid_v;
	assign empty_o    = ~out_valid_o;

	// output entry; cleared when empty so idle shows all zeros
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			out_beat_o  <= '0;
			out_valid_o <= 1'b0;
		end else if (~out_valid_o | pop) begin
			if (skid_v) begin
				out_beat_o  <= skid;
				out_valid_o <= 1'b1;
			end else if (push) begin
				out_beat_o  <= in_beat_i;
				out_valid_o <= 1'b1;
			end else begin
				out_beat_o  <= '0;
				out_valid_o <= 1'b0;
			end
		end
	end

	// skid entry; filled only while output stalls
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			skid   <= '0;
			skid_v <= 1'b0;
		end else if (~out_valid_o | pop) begin
			skid   <= '0;
			skid_v <= 1'b0;
		end else if (push) begin
			skid   <= in_beat_i;
			skid_v <= 1'b1;
		end
	end

endmodule

// ==== rtl/rxu_core.sv ====
// receive user burst interface with reset and link bring-up
// assumes deframed beats on the in_* group, a wishbone classic master,
// and lane lock indications from the receive lanes
//
// Our own choices: the Wishbone slave port and the register addresses.
`timescale 1ns/1ps
`include "rxu_consts.svh"

module rxu_core (
	input  wire logic                   clk_i,
	input  wire logic                   reset_n_i,
	// wishbone classic slave
	input  wire logic                   wb_cyc_i,
	input  wire logic                   wb_stb_i,
	input  wire logic                   wb_we_i,
	input  wire logic [4:0]             wb_adr_i,
	input  wire logic [3:0]             wb_sel_i,
	input  wire logic [31:0]            wb_dat_i,
	output logic [31:0]                 wb_dat_o,
	output logic                        wb_ack_o,
	// lane lock indications
	input  wire logic                   lane_word_lock_i,
	input  wire logic                   lane_frame_lock_i,
	input  wire logic                   lane_align_i,
	// link status
	output logic                        tx_lanes_aligned_o,
	output logic                        frame_locked_o,
	output logic                        word_locked_o,
	output logic                        rx_lanes_aligned_o,
	// deframed beats
	input  wire logic                   in_valid_i,
	output logic                        in_ready_o,
	input  wire rxu_pkg::rxu_in_t       in_beat_i,
	// application side
	input  wire logic                   rx_ready_i,
	output logic [1:0]                  rx_sop_o,
	output logic [1:0]                  rx_sob_o,
	output logic                        rx_eob_o,
	output logic [`RXU_CHAN_BITS-1:0]   rx_chan_o,
	output logic [7:0]                  rx_num_valid_o,
	output logic [3:0]                  rx_eopbits_o,
	output logic [`RXU_WORDS*`RXU_WORD_BITS-1:0] rx_dout_words_o
);

	// ------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------
	logic [1:0]             rst_sync;
	logic                   rst;
	rxu_pkg::rxu_state_t    state;
	rxu_pkg::rxu_state_t    next_state;
	logic [7:0]             seq_cnt;
	logic                   seq_done;
	logic                   ctrl_en;
	logic                   bad_seen;
	logic [31:0]            beat_cnt;
	logic [31:0]            pkt_cnt;
	logic [31:0]            err_cnt;
	logic                   wb_req;
	logic                   wb_wr;
	logic                   clr_pulse;
	logic                   st_clr;
	logic                   path_on;
	logic                   take;
	logic                   cnt_bad;
	logic                   push;
	logic                   drop_bad;
	logic                   in_burst;
	logic                   buf_ready;
	logic                   buf_full;
	logic                   buf_empty;
	logic                   out_valid;
	logic [3:0]             cnt;
	logic [3:0]             bytes_n;
	logic [`RXU_WORDS*`RXU_WORD_BITS-1:0] packed_data;
	rxu_pkg::rxu_beat_t     beat;
	rxu_pkg::rxu_beat_t     out_beat;
	logic [31:0]            status_word;

	// ------------------------------------------------------------
	// reset
	// ------------------------------------------------------------
	// async assert, sync release
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rst_sync <= 2'b00;
		end else begin
			rst_sync <= {rst_sync[0], 1'b1};
		end
	end

	assign rst = ~rst_sync[1];

	// ------------------------------------------------------------
	// bring-up sequence
	// ------------------------------------------------------------
	// sequence counter runs only in ST_SEQ
	always_ff @(posedge clk_i) begin
		if (rst) begin
			seq_cnt <= `RXU_SEQ_CYCLES;
		end else if (state == rxu_pkg::ST_SEQ && seq_cnt != 8'h00) begin
			seq_cnt <= seq_cnt - `RXU_SEQ_ONE;
		end
	end

	assign seq_done = (seq_cnt == 8'h00);

	always_comb begin
		next_state = state;
		unique case (state)
			rxu_pkg::ST_RESET: begin
				next_state = rxu_pkg::ST_SEQ;
			end
			rxu_pkg::ST_SEQ: begin
				if (seq_done) begin
					next_state = rxu_pkg::ST_LINK;
				end
			end
			rxu_pkg::ST_LINK: begin
				if (lane_word_lock_i & lane_frame_lock_i & lane_align_i) begin
					next_state = rxu_pkg::ST_UP;
				end
			end
			rxu_pkg::ST_UP: begin
				if (~(lane_word_lock_i & lane_frame_lock_i & lane_align_i)) begin
					next_state = rxu_pkg::ST_LINK;
				end
			end
		endcase
	end

	// state register
	always_ff @(posedge clk_i) begin
		if (rst) begin
			state <= rxu_pkg::ST_RESET;
		end else begin
			state <= next_state;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst) begin
			tx_lanes_aligned_o <= 1'b0;
			word_locked_o      <= 1'b0;
			frame_locked_o     <= 1'b0;
			rx_lanes_aligned_o <= 1'b0;
		end else begin
			tx_lanes_aligned_o <= (next_state == rxu_pkg::ST_LINK) |
				(next_state == rxu_pkg::ST_UP);
			word_locked_o      <= (next_state == rxu_pkg::ST_LINK |
				next_state == rxu_pkg::ST_UP) & lane_word_lock_i;
			frame_locked_o     <= (next_state == rxu_pkg::ST_LINK |
				next_state == rxu_pkg::ST_UP) & lane_word_lock_i &
				lane_frame_lock_i;
			rx_lanes_aligned_o <= (next_state == rxu_pkg::ST_UP);
		end
	end

	// ------------------------------------------------------------
	// wishbone slave
	// ------------------------------------------------------------
	assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign wb_wr  = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i & wb_sel_i[0];

	// ack one cycle after the request, dropped the cycle after
	always_ff @(posedge clk_i) begin
		if (rst) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= wb_req;
		end
	end

	assign clr_pulse = wb_wr & (wb_adr_i == `RXU_ADR_CTRL) &
		wb_dat_i[`RXU_CTRL_CLR];
	assign st_clr    = wb_wr & (wb_adr_i == `RXU_ADR_STATUS) &
		wb_dat_i[`RXU_ST_BADCNT];

	// control register: delivery enable
	always_ff @(posedge clk_i) begin
		if (rst) begin
			ctrl_en <= 1'b1;
		end else if (wb_wr && wb_adr_i == `RXU_ADR_CTRL) begin
			ctrl_en <= wb_dat_i[`RXU_CTRL_EN];
		end
	end

	// sticky bad count flag; a new event wins over the clear
	always_ff @(posedge clk_i) begin
		if (rst) begin
			bad_seen <= 1'b0;
		end else if (drop_bad) begin
			bad_seen <= 1'b1;
		end else if (st_clr) begin
			bad_seen <= 1'b0;
		end
	end

	// ready bit tells software the sequence has finished
	always_comb begin
		status_word                  = 32'h0000_0000;
		status_word[`RXU_ST_READY]   = (state == rxu_pkg::ST_LINK) |
			(state == rxu_pkg::ST_UP);
		status_word[`RXU_ST_TXAL]    = tx_lanes_aligned_o;
		status_word[`RXU_ST_WORD]    = word_locked_o;
		status_word[`RXU_ST_FRAME]   = frame_locked_o;
		status_word[`RXU_ST_RXAL]    = rx_lanes_aligned_o;
		status_word[`RXU_ST_FULL]    = buf_full;
		status_word[`RXU_ST_EMPTY]   = buf_empty;
		status_word[`RXU_ST_BADCNT]  = bad_seen;
	end

	// read data, zero for unmapped offsets
	always_ff @(posedge clk_i) begin
		if (rst) begin
			wb_dat_o <= 32'h0000_0000;
		end else if (wb_req) begin
			unique case (wb_adr_i)
				`RXU_ADR_CTRL:   wb_dat_o <= {31'h0000_0000, ctrl_en};
				`RXU_ADR_STATUS: wb_dat_o <= status_word;
				`RXU_ADR_BEATS:  wb_dat_o <= beat_cnt;
				`RXU_ADR_PKTS:   wb_dat_o <= pkt_cnt;
				`RXU_ADR_ERRS:   wb_dat_o <= err_cnt;
				default:         wb_dat_o <= 32'h0000_0000;
			endcase
		end
	end

	// ------------------------------------------------------------
	// intake of deframed beats
	// ------------------------------------------------------------
	assign path_on  = ctrl_en & (state == rxu_pkg::ST_UP);
	// beats arriving while the path is off are taken and dropped
	assign in_ready_o = buf_ready | ~path_on;
	assign take     = in_valid_i & in_ready_o;
	assign cnt      = in_beat_i.count;
	assign cnt_bad  = (cnt > `RXU_CNT_FULL);
	// zero count is idle, never forwarded
	assign push     = take & path_on & ~cnt_bad & (cnt != `RXU_CNT_IDLE);
	assign drop_bad = take & path_on & cnt_bad;
	// a zero byte count means the whole last word
	assign bytes_n  = (in_beat_i.last_bytes == 3'b000) ? 4'h8 :
		{1'b0, in_beat_i.last_bytes};

	// ------------------------------------------------------------
	// word and byte placement
	// ------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < `RXU_WORDS*`RXU_WORD_BYTES; gi++) begin : g_byte
			localparam logic [3:0] SLOT = 4'(gi / `RXU_WORD_BYTES);
			localparam logic [3:0] BYTE = 4'(gi % `RXU_WORD_BYTES);
			localparam logic [3:0] SRC  = 4'(`RXU_WORDS - 1) - SLOT;
			localparam int         IDX  = (`RXU_WORDS - 1 - gi / 8) *
				`RXU_WORD_BITS + (gi % 8) * 8;
			logic keep;
			// trim low bytes of the final word
			assign keep = ~(in_beat_i.eop && SRC == cnt - 4'h1 &&
				BYTE < 4'h8 - bytes_n);
			// source word k lands in slot 7-k
			assign packed_data[gi*8 +: 8] = (SRC < cnt && keep) ?
				in_beat_i.data[IDX +: 8] : 8'h00;
		end
	endgenerate

	// ------------------------------------------------------------
	// burst tracking
	// ------------------------------------------------------------
	// open burst state; channel may change between bursts
	always_ff @(posedge clk_i) begin
		if (rst) begin
			in_burst <= 1'b0;
		end else if (push) begin
			in_burst <= ~(in_beat_i.eob | in_beat_i.eop);
		end
	end

	// assemble the delivered beat
	always_comb begin
		beat           = '0;
		beat.chan      = in_beat_i.chan;
		beat.data      = packed_data;
		// start of packet also starts a burst
		beat.sop[1]    = in_beat_i.sop;
		beat.sop[0]    = 1'b0;
		beat.sob[0]    = 1'b0;
		// start on first cycle of a burst
		beat.sob[1]    = ~in_burst | in_beat_i.sop;
		// eob may share the cycle with sob
		beat.eob       = in_beat_i.eob | in_beat_i.eop;
		// full bus reads as 1000 in the upper nibble
		beat.num_valid = {cnt, `RXU_NV_LOW_UNUSED};
		// top bit end, low bits byte count
		// continuation keeps the field at zero
		beat.eopbits   = in_beat_i.eop ?
			{1'b1, in_beat_i.last_bytes} : `RXU_EOP_NONE;
	end

	// ------------------------------------------------------------
	// counters
	// ------------------------------------------------------------
	// delivered beats
	always_ff @(posedge clk_i) begin
		if (rst | clr_pulse) begin
			beat_cnt <= 32'h0000_0000;
		end else if (push) begin
			beat_cnt <= beat_cnt + `RXU_CNT_ONE;
		end
	end

	// completed packets
	always_ff @(posedge clk_i) begin
		if (rst | clr_pulse) begin
			pkt_cnt <= 32'h0000_0000;
		end else if (push & in_beat_i.eop) begin
			pkt_cnt <= pkt_cnt + `RXU_CNT_ONE;
		end
	end

	// beats dropped for an out-of-range count
	always_ff @(posedge clk_i) begin
		if (rst | clr_pulse) begin
			err_cnt <= 32'h0000_0000;
		end else if (drop_bad) begin
			err_cnt <= err_cnt + `RXU_CNT_ONE;
		end
	end

	// ------------------------------------------------------------
	// output buffer
	// ------------------------------------------------------------
	// outputs from flops, zero while empty
	rxu_skid u_skid (
		.clk_i       (clk_i),
		.rst_i       (rst),
		.in_valid_i  (push),
		.in_ready_o  (buf_ready),
		.in_beat_i   (beat),
		.out_valid_o (out_valid),
		.out_ready_i (rx_ready_i),
		.out_beat_o  (out_beat),
		.full_o      (buf_full),
		.empty_o     (buf_empty)
	);

	// channel stays on the bus only with its beat
	assign rx_sop_o        = out_beat.sop;
	assign rx_sob_o        = out_beat.sob;
	assign rx_eob_o        = out_beat.eob;
	assign rx_chan_o       = out_beat.chan;
	assign rx_num_valid_o  = out_beat.num_valid;
	assign rx_eopbits_o    = out_beat.eopbits;
	assign rx_dout_words_o = out_beat.data;

endmodule

// ==== test/rxu_core_properties.sv ====
// assertions on the ports of the receive burst interface core
// assumes the core's port list as declared; bound at the foot
`timescale 1ns/1ps
`include "rxu_consts.svh"

module rxu_core_checker (
	input wire logic       clk_i,
	input wire logic       reset_n_i,
	input wire logic       wb_cyc_i,
	input wire logic       wb_stb_i,
	input wire logic       wb_ack_o,
	input wire logic       tx_lanes_aligned_o,
	input wire logic       frame_locked_o,
	input wire logic       word_locked_o,
	input wire logic       rx_lanes_aligned_o,
	input wire logic       rx_ready_i,
	input wire logic [1:0] rx_sop_o,
	input wire logic [1:0] rx_sob_o,
	input wire logic       rx_eob_o,
	input wire logic [`RXU_CHAN_BITS-1:0] rx_chan_o,
	input wire logic [7:0] rx_num_valid_o,
	input wire logic [3:0] rx_eopbits_o,
	input wire logic [`RXU_WORDS*`RXU_WORD_BITS-1:0] rx_dout_words_o
);
	logic       vld;
	logic       need_sob;
	logic [5:0] up_cnt;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);

	// a beat is presented
	assign vld = rx_num_valid_o[7:4] != 4'h0;

	// next taken beat must open a burst
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			need_sob <= 1'b1;
		end else if (vld && rx_ready_i) begin
			need_sob <= rx_eob_o;
		end
	end

	// cycles since reset release, saturating
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			up_cnt <= 6'h00;
		end else if (up_cnt != 6'h3F) begin
			up_cnt <= up_cnt + 6'h01;
		end
	end

	seg_low_zero_a: assert property (
		rx_sop_o[0] == 1'b0 && rx_sob_o[0] == 1'b0 &&
		rx_num_valid_o[3:0] == 4'h0) else $error("lower segment driven");
	sop_sob_a: assert property (rx_sop_o[1] |-> rx_sob_o[1])
		else $error("sop without sob");
	eop_eob_a: assert property (rx_eopbits_o[3] |-> rx_eob_o)
		else $error("eop without eob");
	eop_clean_a: assert property (
		!rx_eopbits_o[3] |-> rx_eopbits_o[2:0] == 3'h0)
		else $error("byte count without eop");
	idle_quiet_a: assert property (!vld |->
		{rx_sop_o, rx_sob_o, rx_eob_o, rx_eopbits_o} == 9'h000 &&
		rx_dout_words_o == '0) else $error("idle cycle not quiet");
	count_max_a: assert property (vld |-> rx_num_valid_o[7:4] <= 4'h8)
		else $error("word count above eight");
	burst_open_a: assert property (vld && need_sob |-> rx_sob_o[1])
		else $error("burst start missing");
	beat_hold_a: assert property (vld && !rx_ready_i |=>
		$stable({rx_sop_o, rx_sob_o, rx_eob_o, rx_chan_o, rx_num_valid_o,
		rx_eopbits_o, rx_dout_words_o})) else $error("stalled beat moved");
	// one-cycle acknowledge
	ack_once_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=>
		wb_ack_o ##1 !wb_ack_o) else $error("ack not a single pulse");
	seq_quiet_a: assert property (up_cnt < 6'h20 |->
		!tx_lanes_aligned_o && !rx_lanes_aligned_o)
		else $error("link status before sequence end");
	link_up_a: assert property (up_cnt == 6'h28 |-> tx_lanes_aligned_o)
		else $error("tx alignment not raised");
	lock_order_a: assert property (rx_lanes_aligned_o |->
		word_locked_o && frame_locked_o) else $error("aligned without lock");
endmodule

bind rxu_core rxu_core_checker chk (.clk_i, .reset_n_i, .wb_cyc_i,
	.wb_stb_i, .wb_ack_o, .tx_lanes_aligned_o, .frame_locked_o,
	.word_locked_o, .rx_lanes_aligned_o, .rx_ready_i, .rx_sop_o, .rx_sob_o,
	.rx_eob_o, .rx_chan_o, .rx_num_valid_o, .rx_eopbits_o,
	.rx_dout_words_o);

// ==== test/rxu_app_model.sv ====
// application logic taking delivered bursts
// assumes beats qualified by a nonzero upper valid count
`timescale 1ns/1ps

module rxu_app_model (
	input  wire logic               clk_i,
	input  wire logic               reset_n_i,
	input  wire logic               slow_i,
	input  wire rxu_pkg::rxu_beat_t beat_i,
	output logic                    rx_ready_o
);
	logic [1:0]         phase;
	logic [7:0]         chan_cap;
	rxu_pkg::rxu_beat_t got_q[$];

	// ready every cycle, or one cycle in four when slow
	always @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			phase <= 2'h0;
			rx_ready_o <= 1'b0;
		end else begin
			phase <= phase + 2'h1;
			rx_ready_o <= !slow_i || phase == 2'h3;
		end
	end

	// keep beats taken at this edge
	always @(posedge clk_i) begin
		if (reset_n_i && beat_i.num_valid[7:4] != 4'h0 && rx_ready_o) begin
			got_q.push_back(beat_i);
			if (beat_i.sop[1]) begin
				chan_cap <= beat_i.chan;
			end
		end
	end
endmodule

// ==== test/tb.sv ====
// self-checking bench for the receive burst interface core
// assumes the checker and application model are compiled first
`timescale 1ns/1ps
`include "rxu_consts.svh"

module tb;
	localparam int CW = $bits(rxu_pkg::rxu_beat_t);
	logic clk_i, reset_n_i, cyc, stb, we, ack, wl, fl, al;
	logic txal, frl, wdl, rxal, in_valid, in_ready, rdy, slow;
	logic exp_sob, en, refused, eob;
	logic [4:0]         adr;
	logic [3:0]         sel, eopb;
	logic [31:0]        wdat, rdat, q;
	logic [1:0]         sop, sob;
	logic [7:0]         chan, nv, sop_chan;
	logic [511:0]       dout;
	rxu_pkg::rxu_in_t   in_beat, b;
	rxu_pkg::rxu_beat_t ob;
	rxu_pkg::rxu_beat_t exp_q[$];
	int                 seed, err_count, n_checks, n_del, n_eop, n;
	logic [15:0]        doc_seq[8] = '{16'h8802, 16'h4802, 16'hE304,
		16'h4000, 16'h4802, 16'hC803, 16'h8805, 16'h6205};

	rxu_core dut (.clk_i, .reset_n_i, .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
		.wb_dat_o(rdat), .wb_ack_o(ack), .lane_word_lock_i(wl),
		.lane_frame_lock_i(fl), .lane_align_i(al),
		.tx_lanes_aligned_o(txal), .frame_locked_o(frl),
		.word_locked_o(wdl), .rx_lanes_aligned_o(rxal),
		.in_valid_i(in_valid), .in_ready_o(in_ready), .in_beat_i(in_beat),
		.rx_ready_i(rdy), .rx_sop_o(sop), .rx_sob_o(sob), .rx_eob_o(eob),
		.rx_chan_o(chan), .rx_num_valid_o(nv), .rx_eopbits_o(eopb),
		.rx_dout_words_o(dout));
	assign ob = {sop, sob, eob, chan, nv, eopb, dout};
	rxu_app_model app (.clk_i, .reset_n_i, .slow_i(slow), .beat_i(ob),
		.rx_ready_o(rdy));

	// 50 MHz clock
	initial begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end

	task automatic check(input logic [CW-1:0] got, input logic [CW-1:0] ex);
		n_checks++;
		if (got !== ex) begin
			err_count++;
			$display("[FAIL] %0t value mismatch", $time);
		end
	endtask

	task automatic print_verdict();
		$display("checks %0d errors %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// classic single wishbone cycle
	task automatic wb(input logic w, input logic [4:0] a,
		input logic [31:0] d, output logic [31:0] r);
		int k;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		sel <= 4'hF;
		k = 0;
		do begin
			@(posedge clk_i);
			k++;
		end while (ack !== 1'b1 && k < 50);
		r = rdat;
		check(CW'(ack), CW'(1'h1));
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		@(posedge clk_i);
	endtask

	// expected delivered beat for a taken input beat
	function automatic rxu_pkg::rxu_beat_t mk_exp(input rxu_pkg::rxu_in_t i,
		input logic s);
		rxu_pkg::rxu_beat_t e;
		int w;
		e = '0;
		e.sop = {i.sop, 1'b0};
		e.sob = {s | i.sop, 1'b0};
		e.eob = i.eob | i.eop;
		e.chan = i.chan;
		e.num_valid = {i.count, 4'h0};
		e.eopbits = i.eop ? {1'b1, i.last_bytes} : 4'h0;
		for (int k = 0; k < 8; k++)
			if (k < i.count) e.data[(7-k)*64 +: 64] = i.data[k*64 +: 64];
		w = 8 - i.count;
		for (int y = 0; y < 8; y++)
			if (i.eop && i.last_bytes != 3'h0 && y < 8 - i.last_bytes)
				e.data[w*64 + y*8 +: 8] = 8'h00;
		return e;
	endfunction

	function automatic rxu_pkg::rxu_in_t rnd_beat();
		rxu_pkg::rxu_in_t r;
		r = '0;
		for (int i = 0; i < 16; i++) r.data[i*32 +: 32] = $random(seed);
		{r.sop, r.eob, r.eop, r.last_bytes, r.chan} = 14'($random(seed));
		r.count = 4'(($random(seed) & 7) + 1);
		return r;
	endfunction

	// offer one beat until taken, note what should appear
	task automatic send(input rxu_pkg::rxu_in_t i);
		int k;
		in_valid <= 1'b1;
		in_beat <= i;
		k = 0;
		do begin
			@(posedge clk_i);
			k++;
			if (in_ready !== 1'b1) refused = 1'b1;
		end while (in_ready !== 1'b1 && k < 200);
		if (en && i.count != 4'h0 && i.count <= 4'h8) begin
			exp_q.push_back(mk_exp(i, exp_sob));
			exp_sob = i.eob | i.eop;
			n_del++;
			n_eop += int'(i.eop);
			if (i.sop) sop_chan = i.chan;
		end
	endtask

	// main sequence
	initial begin
		{cyc, stb, we, in_valid, slow, refused} = 6'h00;
		{adr, sel, wdat, in_beat} = '0;
		{wl, fl, al, en, exp_sob} = 5'h1F;
		err_count = 0;
		n_checks = 0;
		n_del = 0;
		n_eop = 0;
		sop_chan = 8'h00;
		seed = 90;
		reset_n_i = 1'b0;
		repeat (8) @(posedge clk_i);
		reset_n_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		n = 0;
		do begin
			wb(1'b0, `RXU_ADR_STATUS, 32'h0, q);
			n++;
		end while (q[0] !== 1'b1 && n < 100);
		check(CW'(q[6:0]), CW'(7'h5F));
		check(CW'({txal, frl, wdl, rxal}), CW'(4'hF));
		wb(1'b0, 5'h14, 32'h0, q);
		check(CW'(q), CW'(32'h0));
		// documented burst train, idle in cycle 4
		foreach (doc_seq[i]) begin
			b = rnd_beat();
			{b.sop, b.eob, b.eop} = doc_seq[i][15:13];
			b.count = doc_seq[i][11:8];
			b.chan = doc_seq[i][7:0];
			b.last_bytes = 3'h3;
			send(b);
		end
		b.count = 4'h9;
		send(b);
		in_valid <= 1'b0;
		wb(1'b1, `RXU_ADR_CTRL, 32'h0, q);
		en = 1'b0;
		b.count = 4'h4;
		send(b);
		in_valid <= 1'b0;
		wb(1'b1, `RXU_ADR_CTRL, 32'h1, q);
		en = 1'b1;
		// random traffic against a slow application
		slow <= 1'b1;
		for (int i = 0; i < 40; i++) begin
			b = rnd_beat();
			b.eob = b.eob | (i == 39);
			send(b);
		end
		in_valid <= 1'b0;
		slow <= 1'b0;
		n = 0;
		while (app.got_q.size() < exp_q.size() && n < 2000) begin
			@(posedge clk_i);
			n++;
		end
		repeat (4) @(posedge clk_i);
		check(CW'(refused), CW'(1'h1));
		check(CW'(app.got_q.size()), CW'(exp_q.size()));
		check(CW'(app.chan_cap), CW'(sop_chan));
		while (exp_q.size() != 0 && app.got_q.size() != 0) begin
			check(app.got_q.pop_front(), exp_q.pop_front());
		end
		wb(1'b0, `RXU_ADR_BEATS, 32'h0, q);
		check(CW'(q), CW'(n_del));
		wb(1'b0, `RXU_ADR_PKTS, 32'h0, q);
		check(CW'(q), CW'(n_eop));
		wb(1'b0, `RXU_ADR_ERRS, 32'h0, q);
		check(CW'(q), CW'(32'h1));
		wb(1'b0, `RXU_ADR_STATUS, 32'h0, q);
		check(CW'(q[8]), CW'(1'h1));
		wb(1'b1, `RXU_ADR_STATUS, 32'h100, q);
		wb(1'b0, `RXU_ADR_STATUS, 32'h0, q);
		check(CW'(q[8]), CW'(1'h0));
		wb(1'b1, `RXU_ADR_CTRL, 32'h3, q);
		wb(1'b0, `RXU_ADR_BEATS, 32'h0, q);
		check(CW'(q), CW'(32'h0));
		al <= 1'b0;
		repeat (4) @(posedge clk_i);
		check(CW'(rxal), CW'(1'h0));
		print_verdict();
	end

	// watchdog against a hang
	initial begin
		repeat (20000) @(posedge clk_i);
		err_count++;
		print_verdict();
	end
endmodule
